// ### bfcu_consts.vh
// Constants for the branch and flow control unit.
// Assumes it is included by bare name from the design files.
// Notes on behaviour
// - Before resolving a bit-testing branch, every pipeline is checked for a pending writer of that bit.
// - With no pending writer, the branch resolves at once from the bit and its own action.
// - Every branch target is word aligned, its two low bits forced to zero.
// - Six target modes: relative, conditional relative, absolute, conditional absolute, via return address, via count.
// - Branches, condition logic ops and the field move all execute in this unit.
// - When the tested bit resolves, the predicted direction is marked correct or mispredicted.
// - A misprediction flushes younger speculative work and restores state to just after the branch.
// - A condition logic op or field move with the link update option set is an invalid form.
// - A trap tests its selected conditions and calls the handler if any holds, else falls through.
// - A one-field condition move goes to a simple integer unit with its field renamed.
// - A zero- or multi-field condition move goes to the multi-cycle unit and sets the scoreboard bit.
// - While the scoreboard bit is set, multi-field moves, count/link writes, condition branches and logic ops are held.
// - The scoreboard bit clears when the instruction that set it has executed.
// - Two one-field condition moves may execute together without scoreboard stalls.
`ifndef BFCU_CONSTS_VH
`define BFCU_CONSTS_VH
// ==========================================================================
// Operation codes
`define BFCU_OP_NONE   4'h0
`define BFCU_OP_B_REL  4'h1
`define BFCU_OP_BC_REL 4'h2
`define BFCU_OP_B_ABS  4'h3
`define BFCU_OP_BC_ABS 4'h4
`define BFCU_OP_BC_RET 4'h5
`define BFCU_OP_BC_CNT 4'h6
`define BFCU_OP_CRLOG  4'h7
`define BFCU_OP_CRMOVE 4'h8
`define BFCU_OP_TRAP   4'h9
`define BFCU_OP_MTCRF  4'ha
`define BFCU_OP_MTCNT  4'hb
`define BFCU_OP_MTRET  4'hc
// ==========================================================================
// Condition logic functions
`define BFCU_LOG_AND  3'h0
`define BFCU_LOG_OR   3'h1
`define BFCU_LOG_XOR  3'h2
`define BFCU_LOG_NAND 3'h3
`define BFCU_LOG_NOR  3'h4
`define BFCU_LOG_EQV  3'h5
`define BFCU_LOG_ANDC 3'h6
`define BFCU_LOG_ORC  3'h7
// ==========================================================================
// Issue routes for condition moves
`define BFCU_ROUTE_NONE  2'h0
`define BFCU_ROUTE_SIU0  2'h1
`define BFCU_ROUTE_SIU1  2'h2
`define BFCU_ROUTE_MULTI 2'h3
// ==========================================================================
// Reset values and pipeline count
`define BFCU_COND_RESET 32'h0000_0000
`define BFCU_PIPES      4
`endif

// ### bfcu_field_store.v
// Condition bit store with a registered read port.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "bfcu_consts.vh"
module bfcu_field_store (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_b,
   // Write side
   input  wire [31:0] wr_mask,
   input  wire [31:0] wr_data,
   // Read side
   output reg  [31:0] rd_bits
);
   // ======================================================================
   // Storage
   reg [31:0] condition_bits_reg;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         condition_bits_reg <= `BFCU_COND_RESET;
         rd_bits            <= `BFCU_COND_RESET;
      end else begin
         condition_bits_reg <= (condition_bits_reg & ~wr_mask) |
                               (wr_data & wr_mask);
         rd_bits            <= (condition_bits_reg & ~wr_mask) |
                               (wr_data & wr_mask);
      end
   end
endmodule // bfcu_field_store
`default_nettype wire

// ### bfcu_branch_flow.v
// Branch and flow control unit: resolution, targets, traps, moves.
// Assumes dispatch holds an op while issue_ready is low, and that the
// pipelines report pending condition-bit writers as a bit mask each.
`timescale 1ns/1ps
`default_nettype none
`include "bfcu_consts.vh"
module bfcu_branch_flow #(
   parameter NPIPE = `BFCU_PIPES
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             rst_b,
   // Dispatched operation
   input  wire             op_valid,
   input  wire [3:0]       op_code,
   input  wire [31:0]      op_pc,
   input  wire [31:0]      op_disp,
   input  wire [4:0]       op_bit_a,
   input  wire [4:0]       op_bit_b,
   input  wire [4:0]       op_bit_d,
   input  wire [2:0]       op_func,
   input  wire             op_link,
   input  wire             op_pred_taken,
   input  wire [7:0]       op_field_mask,
   input  wire [31:0]      op_data,
   input  wire [4:0]       op_trap_sel,
   input  wire [4:0]       op_trap_cond,
   output wire             issue_ready,
   // Pending writers, one mask of condition bits per pipeline
   input  wire [32*NPIPE-1:0] pipe_pending,
   // Executed notice from the multi-cycle unit
   input  wire             multicycle_done,
   // Operand registers
   input  wire [31:0]      count_reg,
   input  wire [31:0]      return_address_reg,
   // Results
   output reg              resolve_valid,
   output reg              mispredict,
   output reg              flush,
   output reg  [31:0]      fetch_target,
   output reg              redirect,
   output reg              trap_req,
   output reg              invalid_form,
   output reg  [1:0]       move_route,
   output reg  [31:0]      move_data,
   output reg  [7:0]       move_field_mask,
   output reg              scoreboard,
   output wire [31:0]      condition_bits
);
   // ======================================================================
   // Helpers
   function [31:0] bfcu_align;
      input [31:0] a;
      bfcu_align = {a[31:2], 2'b00};
   endfunction
   function [3:0] bfcu_popcnt;
      input [7:0] m;
      integer i;
      begin
         bfcu_popcnt = 4'h0;
         for (i = 0; i < 8; i = i + 1)
            bfcu_popcnt = bfcu_popcnt + {3'h0, m[i]};
      end
   endfunction
   function [31:0] bfcu_field_bits;
      input [7:0] m;
      integer i;
      begin
         bfcu_field_bits = 32'h0;
         for (i = 0; i < 8; i = i + 1)
            bfcu_field_bits[4*i +: 4] = {4{m[i]}};
      end
   endfunction
   // ======================================================================
   // Pending writer scan
   reg  [31:0] pending_any;
   integer p;
   always @* begin
      pending_any = 32'h0;
      for (p = 0; p < NPIPE; p = p + 1)
         pending_any = pending_any | pipe_pending[32*p +: 32];
   end
   // ======================================================================
   // Decode
   wire is_cond  = (op_code == `BFCU_OP_BC_REL) ||
                   (op_code == `BFCU_OP_BC_ABS) ||
                   (op_code == `BFCU_OP_BC_RET) ||
                   (op_code == `BFCU_OP_BC_CNT);
   wire is_logic = (op_code == `BFCU_OP_CRLOG) ||
                   (op_code == `BFCU_OP_CRMOVE);
   wire is_mtcrf = (op_code == `BFCU_OP_MTCRF);
   wire one_fld  = (bfcu_popcnt(op_field_mask) == 4'h1);
   wire multi    = is_mtcrf && !one_fld;
   wire cl_write = (op_code == `BFCU_OP_MTCNT) ||
                   (op_code == `BFCU_OP_MTRET);
   // Hazard on any bit read by a branch or logic op.
   // A field move reads four bits, so a writer of any of them holds it.
   wire [7:0] src_fld  = 8'h01 << op_bit_a[2:0];
   wire       fld_busy = |(pending_any & bfcu_field_bits(src_fld));
   wire hazard = (is_cond && pending_any[op_bit_a]) ||
                 (op_code == `BFCU_OP_CRLOG && (pending_any[op_bit_a] ||
                  pending_any[op_bit_b])) ||
                 (op_code == `BFCU_OP_CRMOVE && fld_busy);
   // Scoreboard hold covers only ops that would race the multi-cycle write.
   wire sb_hold = scoreboard && (multi || cl_write || is_cond ||
                  is_logic);
   // Ready is combinational so a held op goes on the first edge it clears.
   assign issue_ready = !(hazard || sb_hold);
   // An op offered while a flush stands is wrong-path work: taken, no effect.
   wire fire = op_valid && issue_ready && !flush;
   // ======================================================================
   // Condition store
   reg  [31:0] wr_mask;
   reg  [31:0] wr_data;
   wire [31:0] cond_q;
   bfcu_field_store u_store (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .wr_mask (wr_mask),
      .wr_data (wr_data),
      .rd_bits (cond_q)
   );
   assign condition_bits = cond_q;
   wire bit_a = cond_q[op_bit_a];
   wire bit_b = cond_q[op_bit_b];
   reg  log_r;
   always @* begin
      case (op_func)
         `BFCU_LOG_AND:  log_r = bit_a & bit_b;
         `BFCU_LOG_OR:   log_r = bit_a | bit_b;
         `BFCU_LOG_XOR:  log_r = bit_a ^ bit_b;
         `BFCU_LOG_NAND: log_r = ~(bit_a & bit_b);
         `BFCU_LOG_NOR:  log_r = ~(bit_a | bit_b);
         `BFCU_LOG_EQV:  log_r = ~(bit_a ^ bit_b);
         `BFCU_LOG_ANDC: log_r = bit_a & ~bit_b;
         `BFCU_LOG_ORC:  log_r = bit_a | ~bit_b;
         default:        log_r = 1'b0;
      endcase
   end
   // Logic ops and field moves run here; invalid forms write nothing.
   always @* begin
      wr_mask = 32'h0;
      wr_data = 32'h0;
      if (fire && !op_link && op_code == `BFCU_OP_CRLOG) begin
         wr_mask[op_bit_d] = 1'b1;
         wr_data[op_bit_d] = log_r;
      end else if (fire && !op_link && op_code == `BFCU_OP_CRMOVE) begin
         wr_mask = {28'h0, 4'hf} << {op_bit_d[2:0], 2'b00};
         wr_data = {28'h0, cond_q[{op_bit_a[2:0], 2'b00} +: 4]} <<
                   {op_bit_d[2:0], 2'b00};
      end
   end
   // ======================================================================
   // Targets and resolution
   wire [31:0] seq_pc = op_pc + 32'h4;
   reg  [31:0] tgt;
   reg         taken;
   always @* begin
      tgt   = seq_pc;
      taken = 1'b0;
      case (op_code)
         `BFCU_OP_B_REL:  begin tgt = op_pc + op_disp; taken = 1'b1; end
         `BFCU_OP_BC_REL: begin tgt = op_pc + op_disp; taken = bit_a; end
         `BFCU_OP_B_ABS:  begin tgt = op_disp; taken = 1'b1; end
         `BFCU_OP_BC_ABS: begin tgt = op_disp; taken = bit_a; end
         `BFCU_OP_BC_RET: begin tgt = return_address_reg; taken = bit_a; end
         `BFCU_OP_BC_CNT: begin tgt = count_reg; taken = bit_a; end
         default:         begin tgt = seq_pc; taken = 1'b0; end
      endcase
   end
   wire is_branch = is_cond || op_code == `BFCU_OP_B_REL ||
                    op_code == `BFCU_OP_B_ABS;
   // A branch guessed wrong either way is a miss, unconditional ones too.
   wire miss = taken != op_pred_taken;
   wire trap_hit = |(op_trap_sel & op_trap_cond);
   // ======================================================================
   // Result registers
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         resolve_valid   <= 1'b0;
         mispredict      <= 1'b0;
         flush           <= 1'b0;
         redirect        <= 1'b0;
         fetch_target    <= 32'h0;
         trap_req        <= 1'b0;
         invalid_form    <= 1'b0;
         move_route      <= `BFCU_ROUTE_NONE;
         move_data       <= 32'h0;
         move_field_mask <= 8'h0;
      end else begin
         resolve_valid <= fire && is_branch;
         mispredict    <= fire && is_branch && miss;
         flush         <= fire && is_branch && miss;
         redirect      <= fire && is_branch && miss;
         if (fire && is_branch)
            fetch_target <= bfcu_align(taken ? tgt : seq_pc);
         trap_req      <= fire && op_code == `BFCU_OP_TRAP && trap_hit;
         invalid_form  <= fire && is_logic && op_link;
         move_data     <= op_data;
         move_field_mask <= op_field_mask;
         if (fire && is_mtcrf && one_fld)
            // Alternating units lets two one-field moves run together.
            move_route <= op_pc[2] ? `BFCU_ROUTE_SIU1 :
                          `BFCU_ROUTE_SIU0;
         else if (fire && (multi || cl_write))
            move_route <= `BFCU_ROUTE_MULTI;
         else
            move_route <= `BFCU_ROUTE_NONE;
      end
   end
   // ======================================================================
   // Scoreboard: set wins over clear in the same cycle.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         scoreboard <= 1'b0;
      else if (fire && (multi || cl_write))
         scoreboard <= 1'b1;
      else if (multicycle_done)
         scoreboard <= 1'b0;
   end
endmodule // bfcu_branch_flow
`default_nettype wire

// ### bfcu_int_model.sv
// Model of the integer pipelines and the multi-cycle unit.
// Assumes the bench drives pend with the bits that are still to be written.
`timescale 1ns/1ps
`default_nettype none
module bfcu_int_model #(
   parameter int NPIPE = 4,
   parameter int LAT   = 5
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   // Branch side state
   input  wire logic                 scoreboard,
   input  wire logic [31:0]          pend,
   // Answers
   output logic [32*NPIPE-1:0]       pipe_pending,
   output logic                      multicycle_done
);
   int cnt;
   // ======================================================================
   // Writers sit in the last pipe, so a scan of pipe 0 alone misses them.
   assign pipe_pending = {pend, {(32*(NPIPE-1)){1'b0}}};
   // ======================================================================
   // A scoreboarded op finishes LAT cycles after the bit is seen set.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         multicycle_done <= 1'b0;
      end else begin
         multicycle_done <= scoreboard && cnt == LAT;
         cnt <= (scoreboard && cnt < LAT) ? cnt + 1 : 0;
      end
   end
endmodule // bfcu_int_model
`default_nettype wire

// ### bfcu_monitor.sv
// Checker on the top ports of the branch and flow control unit.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "bfcu_consts.vh"
module bfcu_monitor #(parameter NPIPE = 4) (
   // Clock, reset and dispatch
   input wire logic                 sys_clk,
   input wire logic                 rst_b,
   input wire logic                 op_valid,
   input wire logic [3:0]           op_code,
   input wire logic [4:0]           op_bit_a,
   input wire logic                 op_link,
   input wire logic [7:0]           op_field_mask,
   input wire logic                 issue_ready,
   input wire logic [32*NPIPE-1:0]  pipe_pending,
   input wire logic                 multicycle_done,
   // Results
   input wire logic                 resolve_valid,
   input wire logic                 mispredict,
   input wire logic                 flush,
   input wire logic                 redirect,
   input wire logic [31:0]          fetch_target,
   input wire logic                 invalid_form,
   input wire logic [1:0]           move_route,
   input wire logic                 scoreboard
);
   logic [31:0] pend;
   wire tk = op_valid && issue_ready && !flush;
   wire mv = tk && op_code == `BFCU_OP_MTCRF;
   // ======================================================================
   // Union of the pending masks of all pipes.
   always_comb begin
      pend = 32'h0;
      for (int i = 0; i < NPIPE; i++)
         pend = pend | pipe_pending[32*i +: 32];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ======================================================================
   // Properties
   property p_pend;
      op_valid && op_code == `BFCU_OP_BC_REL && pend[op_bit_a] |-> !issue_ready;
   endproperty
   a_pend: assert property (p_pend)
      else $error("branch issued over a pending writer");
   property p_aln;
      redirect |-> fetch_target[1:0] == 2'h0;
   endproperty
   a_aln: assert property (p_aln)
      else $error("unaligned target");
   property p_mis;
      mispredict |-> resolve_valid && flush && redirect;
   endproperty
   a_mis: assert property (p_mis)
      else $error("mispredict without flush");
   property p_inv;
      tk && op_code == `BFCU_OP_CRLOG && op_link |=> invalid_form && !redirect;
   endproperty
   a_inv: assert property (p_inv)
      else $error("invalid form not flagged");
   property p_one;
      mv && $onehot(op_field_mask) |=> move_route inside {2'h1, 2'h2};
   endproperty
   a_one: assert property (p_one)
      else $error("single field move misrouted");
   property p_mul;
      mv && !$onehot(op_field_mask) |=> scoreboard && move_route == 2'h3;
   endproperty
   a_mul: assert property (p_mul)
      else $error("multi field move misrouted");
   property p_sbh;
      scoreboard && op_valid && op_code == `BFCU_OP_MTCNT |-> !issue_ready;
   endproperty
   a_sbh: assert property (p_sbh)
      else $error("held op issued");
   property p_sbc;
      scoreboard && multicycle_done && !tk |=> !scoreboard;
   endproperty
   a_sbc: assert property (p_sbc)
      else $error("scoreboard not cleared");
   property p_sbs;
      scoreboard && !multicycle_done |=> scoreboard;
   endproperty
   a_sbs: assert property (p_sbs)
      else $error("scoreboard dropped early");
endmodule // bfcu_monitor
bind bfcu_branch_flow bfcu_monitor #(.NPIPE(NPIPE)) i_monitor (.*);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the branch and flow control unit.
// Assumes the design, the unit model and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
`include "bfcu_consts.vh"
module testbench;
   logic sys_clk, rst_b, op_valid, op_link, op_pred_taken;
   logic [3:0] op_code;
   logic [2:0] op_func;
   logic [4:0] op_bit_a, op_bit_b, op_bit_d, op_trap_sel, op_trap_cond;
   logic [7:0] op_field_mask;
   logic [31:0] op_pc, op_disp, op_data, count_reg, return_address_reg, pend;
   wire logic issue_ready, resolve_valid, mispredict, flush, redirect;
   wire logic trap_req, invalid_form, scoreboard, multicycle_done;
   wire logic [1:0] move_route;
   wire logic [7:0] move_field_mask;
   wire logic [31:0] fetch_target, move_data, condition_bits;
   wire logic [127:0] pipe_pending;
   int miscompares = 0;
   int n_compared = 0;
   bfcu_branch_flow #(.NPIPE(4)) i_dut (.*);
   bfcu_int_model #(.NPIPE(4)) i_units (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // The whole run is well under a hundred cycles; this span leaves wide margin.
   initial begin
      #20us;
      miscompares++;
      results;
   end
   // ======================================================================
   // Shared tasks
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task results;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Holds the op until taken; returns where the answer pulses stand.
   // Ready is judged just after the falling edge, once it has settled.
   task go;
      int n;
      n = 0;
      op_valid = 1'b1;
      #1;
      while (issue_ready !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         #1;
         n++;
      end
      if (n == 40) chk("issue ready", issue_ready, 1'b1);
      @(negedge sys_clk);
      op_valid = 1'b0;
   endtask
   // ======================================================================
   // Scenarios
   task t_modes;
      logic [3:0] c [6] = '{`BFCU_OP_B_ABS, `BFCU_OP_B_REL, `BFCU_OP_BC_REL,
                            `BFCU_OP_BC_ABS, `BFCU_OP_BC_RET, `BFCU_OP_BC_CNT};
      logic [31:0] e [6] = '{32'h10, 32'h1010, 32'h1010, 32'h10, 32'h2220,
                             32'h3330};
      op_code = `BFCU_OP_CRLOG;
      op_func = `BFCU_LOG_NOR;
      op_bit_d = 5'h03;
      go;
      @(negedge sys_clk);
      chk("logic op", condition_bits[3], 1'b1);
      op_pc = 32'h1000;
      op_disp = 32'h13;
      op_bit_a = 5'h03;
      op_pred_taken = 1'b1;
      for (int i = 0; i < 6; i++) begin
         op_code = c[i];
         go;
         chk("target", fetch_target, e[i]);
         chk("mispredict", mispredict, 1'b0);
      end
      op_code = `BFCU_OP_BC_REL;
      op_bit_a = 5'h04;
      go;
      chk("flush", {mispredict, flush, redirect}, 3'h7);
      chk("fix target", fetch_target, 32'h1004);
      op_code = `BFCU_OP_CRLOG;
      op_func = `BFCU_LOG_OR;
      op_bit_d = 5'h06;
      go;
      @(negedge sys_clk);
      chk("flushed op", condition_bits[6], 1'b0);
      $display("test modes done");
   endtask
   task t_pend;
      op_code = `BFCU_OP_BC_REL;
      op_bit_a = 5'h03;
      pend = 32'h8;
      op_valid = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("held", issue_ready, 1'b0);
      pend = 32'h0;
      go;
      chk("resolved", {resolve_valid, mispredict}, 2'h2);
      $display("test pending done");
   endtask
   task t_forms;
      op_code = `BFCU_OP_CRMOVE;
      op_bit_a = 5'h00;
      op_bit_d = 5'h02;
      go;
      chk("field move", condition_bits[11:8], 4'h8);
      op_code = `BFCU_OP_CRLOG;
      op_func = `BFCU_LOG_OR;
      op_bit_a = 5'h03;
      op_link = 1'b1;
      op_bit_d = 5'h05;
      go;
      chk("invalid", invalid_form, 1'b1);
      @(negedge sys_clk);
      chk("no write", condition_bits[5], 1'b0);
      op_link = 1'b0;
      op_code = `BFCU_OP_TRAP;
      op_trap_sel = 5'h14;
      for (int i = 0; i < 2; i++) begin
         op_trap_cond = i ? 5'h0b : 5'h04;
         go;
         chk("trap", trap_req, i ? 1'b0 : 1'b1);
      end
      $display("test forms done");
   endtask
   task t_moves;
      int n;
      for (int i = 0; i < 2; i++) begin
         op_code = `BFCU_OP_MTCRF;
         op_pc = i ? 32'h4 : 32'h0;
         op_field_mask = i ? 8'h02 : 8'h01;
         op_data = i ? 32'h0000_1234 : 32'h0000_5678;
         go;
         chk("route", move_route, i ? 2'h2 : 2'h1);
         chk("no sb", scoreboard, 1'b0);
         chk("move data", move_data, op_data);
         chk("move mask", move_field_mask, op_field_mask);
      end
      for (int i = 0; i < 2; i++) begin
         op_code = `BFCU_OP_MTCRF;
         op_field_mask = i ? 8'h00 : 8'h03;
         go;
         chk("mc route", move_route, 2'h3);
         chk("sb set", scoreboard, 1'b1);
         op_code = `BFCU_OP_MTCNT;
         op_valid = 1'b1;
         @(negedge sys_clk);
         chk("sb hold", issue_ready, 1'b0);
         go;
         n = 0;
         while (scoreboard !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
         end
         chk("sb clear", scoreboard, 1'b0);
      end
      $display("test moves done");
   endtask
   initial begin
      {rst_b, op_valid, op_link, op_pred_taken, op_code, op_func} = '0;
      {op_bit_a, op_bit_b, op_bit_d, op_trap_sel, op_trap_cond} = '0;
      {op_field_mask, op_pc, op_disp, op_data, pend} = '0;
      count_reg = 32'h3331;
      return_address_reg = 32'h2222;
      repeat (12) @(negedge sys_clk);
      rst_b = 1'b1;
      t_modes;
      t_pend;
      t_forms;
      t_moves;
      results;
   end
endmodule // testbench
`default_nettype wire
